// File: ve_status_scratch_regs.sv
// status, scratch and adc start wait register bank of a vector engine channel
// assumes task/schedule state comes from the sequencer on the same clock
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "ve_status_scratch_params.svh"
module ve_status_scratch_regs
    import ve_status_scratch_pkg::*;
#(
    parameter int WAIT_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [3:0] i_running_task_number,
    input wire logic i_schedule_active,
    input wire logic i_single_shunt_mode,
    input wire logic i_pwm_shift_enable,
    input wire logic [1:0] i_pwm_shift_pattern,
    output logic [15:0] o_adc_wait_count,
    output logic o_adc_wait_apply
);
    initial begin
        if (WAIT_W != 16) $error("ve_status_scratch_regs: WAIT_W must be 16");
    end

    logic [15:0] adc_wait_q;
    logic [31:0] rdata_q;
    logic [15:0] wait_cnt_q;
    logic apply_q;
    logic [1:0] rsel_q;
    logic [31:0] scratch_rdata;
    task_code_t task_now;

    // decode
    wire hit_status = (i_addr == `VE_OFS_STATUS);
    wire hit_scratch = (i_addr >= `VE_OFS_SCRATCH0) && (i_addr <= `VE_OFS_SCRATCH5) && (i_addr[1:0] == 2'b00);
    wire hit_wait = (i_addr == `VE_OFS_ADC_WAIT);
    wire [7:0] scratch_ofs = i_addr - `VE_OFS_SCRATCH0;
    wire [2:0] scratch_idx = scratch_ofs[4:2];
    wire wr_scratch = i_wr && hit_scratch;
    // status writes fall through: no storage behind that offset
    wire wr_wait = i_wr && hit_wait;
    assign task_now = task_code_t'(i_running_task_number);
    wire [31:0] status_word = {22'h00_0000, i_running_task_number, i_schedule_active, 5'h00};
    // shift pattern 1 only; pattern 2 codes never enable the wait
    wire pattern_one = (i_pwm_shift_pattern == `VE_SHIFT_PATTERN_ONE);
    wire wait_cond = i_single_shunt_mode && i_pwm_shift_enable && pattern_one;
    wire use_wait = wait_cond && (task_now == task_out_ctrl1) && i_schedule_active;

    ve_scratch_mem #(.WORDS(6), .WIDTH(32)) u_mem (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_wr(wr_scratch),
        .i_idx(scratch_idx),
        .i_wdata(i_wdata),
        .o_rdata(scratch_rdata)
    );

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) adc_wait_q <= '0;
        else if (wr_wait) adc_wait_q <= i_wdata[`VE_WAIT_MSB:0];
    end

    // status and wait are captured at strobe time; scratch comes from the memory register
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rsel_q <= 2'd0;
            rdata_q <= `VE_RESET_WORD;
        end else begin
            rsel_q <= (i_rd && hit_scratch) ? 2'd1 : 2'd0;
            if (i_rd && hit_status) rdata_q <= status_word;
            else if (i_rd && hit_wait) rdata_q <= {16'h0000, adc_wait_q};
            else rdata_q <= `VE_RESET_WORD;
        end
    end
    // mux after the registers keeps o_rdata registered-sourced
    assign o_rdata = (rsel_q == 2'd1) ? scratch_rdata : rdata_q;

    // wait counter: loads on entering task 0, counts down, apply pulse at the end
    logic in_task0_q;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            in_task0_q <= 1'b0;
            wait_cnt_q <= '0;
            apply_q <= 1'b0;
        end else begin
            in_task0_q <= use_wait;
            apply_q <= 1'b0;
            if (!use_wait) wait_cnt_q <= '0;
            else if (!in_task0_q) wait_cnt_q <= adc_wait_q;
            else if (wait_cnt_q != 16'h0000) wait_cnt_q <= wait_cnt_q - 16'h0001;
            apply_q <= use_wait && in_task0_q && (wait_cnt_q == 16'h0001);
        end
    end
    assign o_adc_wait_count = wait_cnt_q;
    assign o_adc_wait_apply = apply_q;

    a_status_read: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && hit_status |=> o_rdata == $past(status_word)) else $error("status readback wrong");
    a_status_zero: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && hit_status |=> o_rdata[31:10] == 22'h0 && o_rdata[4:0] == 5'h0) else $error("status reserved set");
    a_sched_flag: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_rd && hit_status |=> o_rdata[5] == $past(i_schedule_active)) else $error("schedule flag wrong");
    a_wait_write: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_wait ##1 (i_rd && hit_wait) |=> o_rdata == {16'h0, $past(i_wdata[15:0], 2)}) else $error("wait readback");
    a_scratch_rw: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        wr_scratch ##1 (i_rd && hit_scratch && scratch_idx == $past(scratch_idx) && !i_wr)
        |=> o_rdata == $past(i_wdata, 2)) else $error("scratch readback");
    a_wait_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !wait_cond |=> o_adc_wait_count == 16'h0 && !o_adc_wait_apply) else $error("wait used outside mode");
    a_wait_task0: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_running_task_number != 4'h0 |=> o_adc_wait_count == 16'h0) else $error("wait outside task 0");
    a_wait_load: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        use_wait && !in_task0_q |=> o_adc_wait_count == $past(adc_wait_q)) else $error("wait not loaded");
    a_pattern_two: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_pwm_shift_pattern != 2'h0 |=> !o_adc_wait_apply) else $error("pattern two applied wait");
endmodule : ve_status_scratch_regs

// File: ve_status_scratch_params.svh
// register offsets, field positions and reset values for the vector engine status and scratch bank
// assumes a byte-addressed plain register port; offsets are byte addresses
// Operation
// - status bits 9:6 show running task
// - task codes 0x0 to 0x6 as listed
// - task codes 0x7 to 0xD; 0xE/0xF reserved
// - status bit 5 set while schedule runs
// - six 32-bit scratch words, reset zero
// - adc wait field bits 15:0 read/write
// - wait used only 1-shunt, shift on, pattern 1
// - wait used only by task 0
// - shift pattern code 00 is pattern 1
`ifndef VE_STATUS_SCRATCH_PARAMS_SVH
`define VE_STATUS_SCRATCH_PARAMS_SVH
`define VE_OFS_STATUS 8'h00
`define VE_OFS_SCRATCH0 8'h04
`define VE_OFS_SCRATCH5 8'h18
`define VE_OFS_ADC_WAIT 8'h1C
`define VE_TASK_MSB 9
`define VE_TASK_LSB 6
`define VE_SCHED_BIT 5
`define VE_WAIT_MSB 15
`define VE_RESET_WORD 32'h0000_0000
`define VE_SHIFT_PATTERN_ONE 2'h0
`define VE_TASK_OUT_CTRL1 4'h0
`endif

// File: ve_status_scratch_pkg.sv
// types shared by the vector engine status and scratch bank
// assumes the params header is compiled alongside
package ve_status_scratch_pkg;
    typedef enum logic [3:0] {
        task_out_ctrl1, task_trig_gen, task_in_proc1, task_in_phase, task_in_axis,
        task_cur_ctrl, task_sincos, task_out_axis, task_out_svm, task_out_ctrl2,
        task_in_proc2, task_out_iclarke, task_atan, task_sqrt, task_rsvd_e, task_rsvd_f
    } task_code_t;
endpackage : ve_status_scratch_pkg

// File: ve_scratch_mem.sv
// six-word scratch memory with registered read data
// assumes one write or one read per cycle from the bank decoder
`timescale 1ns/1ps
module ve_scratch_mem #(
    parameter int WORDS = 6,
    parameter int WIDTH = 32
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_wr,
    input wire logic [2:0] i_idx,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_q [WORDS];
    initial begin
        if (WORDS < 1 || WORDS > 8) $error("ve_scratch_mem: WORDS must be 1..8");
    end
    for (genvar g = 0; g < WORDS; g++) begin : g_word
        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) mem_q[g] <= '0;
            else if (i_wr && i_idx == 3'(g)) mem_q[g] <= i_wdata;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) o_rdata <= '0;
        else if (int'(i_idx) < WORDS) o_rdata <= mem_q[i_idx];
        else o_rdata <= '0;
    end
endmodule : ve_scratch_mem

// File: ve_status_scratch_regs_tb.sv
// self-checking bench for the status, scratch and adc start wait bank
// assumes the bench plays both the register master and the sequencer
`timescale 1ns/1ps
module vector_engine_status_scratch_regs_tb;
    logic i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0;
    logic i_schedule_active = 0, i_single_shunt_mode = 0, i_pwm_shift_enable = 0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000, v;
    logic [3:0] i_running_task_number = 4'h0;
    logic [1:0] i_pwm_shift_pattern = 2'h0;
    logic [15:0] first;
    wire [31:0] o_rdata;
    wire [15:0] o_adc_wait_count;
    wire o_adc_wait_apply;
    int n_fail = 0, tests_run = 0, pulses;
    ve_status_scratch_regs uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_running_task_number(i_running_task_number),
        .i_schedule_active(i_schedule_active), .i_single_shunt_mode(i_single_shunt_mode),
        .i_pwm_shift_enable(i_pwm_shift_enable), .i_pwm_shift_pattern(i_pwm_shift_pattern),
        .o_adc_wait_count(o_adc_wait_count), .o_adc_wait_apply(o_adc_wait_apply));
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    function automatic logic [31:0] stat(input logic [3:0] t, input logic f);
        return {22'h0, t, f, 5'h00};
    endfunction : stat
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
        @(posedge i_mclk) i_wr <= 1'b0;
    endtask : wr
    // write then read back with no gap, so the readback assertions see their antecedent
    task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge i_mclk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
        @(posedge i_mclk) begin i_wr <= 1'b0; i_rd <= 1'b1; end
        @(posedge i_mclk) i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask : wrd
    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_mclk) begin i_rd <= 1'b1; i_addr <= a; end
        @(posedge i_mclk) i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask : rd
    // condition must be re-entered, so schedule drops between trials
    task automatic trial(input logic [3:0] t, input logic s, input logic e, input logic [1:0] p, input int want);
        @(posedge i_mclk) begin
            i_running_task_number <= t; i_single_shunt_mode <= s; i_pwm_shift_enable <= e;
            i_pwm_shift_pattern <= p; i_schedule_active <= 1'b1;
        end
        pulses = 0;
        first = 16'h0000;
        repeat (20) begin
            @(posedge i_mclk) #1;
            if (o_adc_wait_apply === 1'b1) pulses++;
            if (first === 16'h0000 && o_adc_wait_count !== 16'h0000) first = o_adc_wait_count;
        end
        chk(pulses, want);
        chk(first, want ? 32'h0000_0002 : 32'h0000_0000);
        @(posedge i_mclk) i_schedule_active <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask : trial
    task automatic conclude;
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        #1_000_000 n_fail++;
        conclude();
    end
    initial begin
        v = $urandom(32'h808d_1e16);
        repeat (20) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        // reset words, including the unmapped slot past the wait register
        for (int a = 0; a <= 32; a += 4) rd(a[7:0], 32'h0000_0000);
        for (int t = 0; t < 16; t++) begin
            @(posedge i_mclk) begin i_running_task_number <= t[3:0]; i_schedule_active <= t[0]; end
            rd(8'h00, stat(t[3:0], t[0]));
        end
        wr(8'h00, $urandom);
        rd(8'h00, stat(4'hf, 1'b1));
        @(posedge i_mclk) i_schedule_active <= 1'b0;
        repeat (3) for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wrd(8'h04 + 8'(4 * i), v, v);
            rd(8'h04 + 8'(4 * i), v);
        end
        v = $urandom;
        wrd(8'h1c, v, {16'h0000, v[15:0]});
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0000_ffff);
        wr(8'h1c, 32'h0000_0002);
        trial(4'h0, 1'b1, 1'b1, 2'h0, 1);
        trial(4'h1, 1'b1, 1'b1, 2'h0, 0);
        trial(4'h0, 1'b0, 1'b1, 2'h0, 0);
        trial(4'h0, 1'b1, 1'b0, 2'h0, 0);
        for (int p = 1; p < 4; p++) trial(4'h0, 1'b1, 1'b1, p[1:0], 0);
        wr(8'h1c, 32'h0000_0000);
        trial(4'h0, 1'b1, 1'b1, 2'h0, 0);
        wr(8'h04, 32'h1234_5678);
        wr(8'h1c, 32'h0000_00ff);
        // second reset in mid-run must clear scratch and wait words
        @(posedge i_mclk) i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(8'h04, 32'h0000_0000);
        rd(8'h1c, 32'h0000_0000);
        conclude();
    end
endmodule : vector_engine_status_scratch_regs_tb
